// ---- dv/cpu_bus_model.sv ----
// Processor bus model: I/O and acknowledge cycles
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
  import interrupt_ack_n_glue_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       cpu_clock_i,
  input  wire logic [1:0] op_i,
  output cpu_bus_t        bus_o
);
  logic       clk_q = 1'b0;
  logic [1:0] rise_q = 2'h0;
  ////////////////////////////////////////
  // Ops: 1 read, 2 write, 3 acknowledge
  always @(negedge mclk_i) begin
    clk_q <= cpu_clock_i;
    if (op_i != 2'h3)
      rise_q <= 2'h0;
    else if (cpu_clock_i && !clk_q && rise_q != 2'h3)
      rise_q <= rise_q + 2'h1;
    bus_o.opcode_fetch_n <= op_i != 2'h3;
    bus_o.io_request_n <= op_i == 2'h0 || (op_i == 2'h3 && rise_q != 2'h3);
    bus_o.rd_n <= op_i != 2'h1;
    bus_o.wr_n <= op_i != 2'h2;
    bus_o.periph_select <= op_i == 2'h1 || op_i == 2'h2;
    bus_o.memory_request_n <= 1'b1;
    // Other logic holds wait through read and write cycles
    bus_o.wait_other_n <= op_i == 2'h0 || op_i == 2'h3;
  end
endmodule
`default_nettype wire

// ---- dv/interrupt_ack_n_bus_glue_test.sv ----
// Self-checking bench for the acknowledge bus glue
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_ack_n_glue_cfg.svh"
module interrupt_ack_n_bus_glue_test;
  import interrupt_ack_n_glue_pkg::*;
  logic        mclk_i, resetn_i, sys_reset_i;
  logic        pend, chain, clr, cpu_clk, ceo, ius, vec;
  logic [1:0]  op;
  cpu_bus_t    cpu;
  periph_bus_t per;
  int          failures, checks;
  cpu_bus_model u_cpu (.mclk_i(mclk_i), .cpu_clock_i(cpu_clk), .op_i(op),
    .bus_o(cpu));
  interrupt_ack_n_bus_glue u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .sys_reset_i(sys_reset_i), .cpu_i(cpu), .pending_flag_i(pend),
    .chain_enable_in_i(chain), .service_clear_i(clr), .periph_o(per),
    .cpu_clock_o(cpu_clk), .chain_enable_out_o(ceo),
    .under_service_o(ius), .vector_enable_o(vec));
  ////////////////////////////////////////
  task automatic chk(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Bit 3 ack, 2 read, 1 write, 0 wait
  task automatic await(input int b, input logic v, input int n,
                       output int i);
    for (i = 0; i < n && per[b] !== v; i++) @(negedge mclk_i);
    chk(per[b], v);
    if (per[b] !== v) conclude();
  endtask
  task automatic t_io(input int b);
    int n;
    op <= (b == 2) ? 2'h1 : 2'h2;
    await(b, 1'b0, 40, n);
    chk(n >= 12, 1'b1);
    chk(per[3 - b], 1'b1);
    chk(per.wait_n, 1'b0);
    op <= 2'h0;
    await(b, 1'b1, 8, n);
    chk(per.wait_n, 1'b1);
  endtask
  task automatic t_clk();
    int hi, lo;
    for (hi = 0; hi < `CPU_DIV && cpu_clk !== 1'b0; hi++) @(negedge mclk_i);
    for (hi = 0; hi < `CPU_DIV && cpu_clk !== 1'b1; hi++) @(negedge mclk_i);
    for (hi = 0; hi < `CPU_DIV && cpu_clk === 1'b1; hi++) @(negedge mclk_i);
    for (lo = 0; lo < `CPU_DIV && cpu_clk === 1'b0; lo++) @(negedge mclk_i);
    chk(hi == `CPU_DIV / 2, 1'b1);
    chk(lo == `CPU_DIV / 2, 1'b1);
  endtask
  task automatic t_ack(input logic ch);
    int n;
    chain = ch;
    pend = 1'b1;
    op <= 2'h3;
    await(3, 1'b0, 80, n);
    @(negedge mclk_i);
    chk(per.wait_n, 1'b0);
    await(2, 1'b0, 700, n);
    chk(n >= 25, 1'b1);
    chk(per.wait_n, 1'b1);
    repeat (3) @(negedge mclk_i);
    chk(vec, ch);
    chk(ius, ch);
    chk(ceo, 1'b0);
    op <= 2'h0;
    await(3, 1'b1, 8, n);
    clr = 1'b1;
    @(negedge mclk_i);
    clr = 1'b0;
    chain = 1'b1;
    repeat (3) @(negedge mclk_i);
    chk(ius, 1'b0);
    chk(ceo, 1'b1);
  endtask
  task automatic t_sys();
    int n;
    sys_reset_i = 1'b1;
    await(2, 1'b0, 8, n);
    chk(per.periph_write_n, 1'b0);
    chk(per.interrupt_ack_n, 1'b1);
    sys_reset_i = 1'b0;
    await(1, 1'b1, 8, n);
  endtask
  ////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial begin
    failures = 0;
    checks = 0;
    {resetn_i, sys_reset_i, pend, chain, clr, op} = 7'h08;
    repeat (10) @(negedge mclk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    chk(per.interrupt_ack_n, 1'b1);
    t_clk();
    t_io(2);
    t_io(1);
    t_ack(1'b1);
    t_ack(1'b0);
    t_sys();
    conclude();
  end
endmodule
`default_nettype wire

// ---- dv/interrupt_ack_n_glue_checker.sv ----
// Port checker for the acknowledge bus glue
`timescale 1ns/1ps
`default_nettype none
module interrupt_ack_n_glue_checker
  import interrupt_ack_n_glue_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        sys_reset_i,
  input wire cpu_bus_t    cpu_i,
  input wire periph_bus_t periph_o,
  input wire logic        vector_enable_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////
  // Cycles with acknowledge low; wide enough for the tap
  logic [9:0] gap_q;
  logic [9:0] gap_d;
  always_comb begin
    gap_d = periph_o.interrupt_ack_n ? 10'h000 : gap_q + 10'h001;
  end
  always_ff @(posedge mclk_i) begin
    gap_q <= resetn_i ? gap_d : 10'h000;
  end
  sequence ack_read;
    !periph_o.interrupt_ack_n && $fell(periph_o.periph_read_n);
  endsequence
  chk_ack_idle: assert property (
    cpu_i.opcode_fetch_n [*5] |-> periph_o.interrupt_ack_n)
    else $error("ack idle");
  chk_wait_idle: assert property (
    (cpu_i.opcode_fetch_n && cpu_i.wait_other_n) [*6] |-> periph_o.wait_n)
    else $error("wait idle");
  chk_ack_cause: assert property (
    $fell(periph_o.interrupt_ack_n) |-> !$past(cpu_i.opcode_fetch_n, 3)
    && $past(cpu_i.memory_request_n, 3)) else $error("ack cause");
  chk_ack_gap: assert property (
    ack_read |-> gap_q >= 10'h019) else $error("ack gap");
  chk_wait_end: assert property (
    ack_read |-> periph_o.wait_n) else $error("wait end");
  chk_vec_gate: assert property (
    vector_enable_o |-> !periph_o.interrupt_ack_n
    && !periph_o.periph_read_n) else $error("vector gate");
  chk_sys_strobes: assert property (
    sys_reset_i [*4] |-> !periph_o.periph_read_n
    && !periph_o.periph_write_n) else $error("sys reset");
  chk_write_lead: assert property (
    $fell(periph_o.periph_write_n) && !$past(sys_reset_i, 3)
    |-> !$past(cpu_i.wr_n, 10)) else $error("write lead");
endmodule
bind interrupt_ack_n_bus_glue interrupt_ack_n_glue_checker u_chk (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .sys_reset_i(sys_reset_i),
  .cpu_i(cpu_i), .periph_o(periph_o), .vector_enable_o(vector_enable_o));
`default_nettype wire

// ---- hdl/interrupt_ack_n_bus_glue.sv ----
// Bus glue between processor bus and serial peripheral
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_ack_n_glue_cfg.svh"
module interrupt_ack_n_bus_glue
  import interrupt_ack_n_glue_pkg::*;
#(
  parameter int unsigned EXTRA_WAIT = 0
)(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        sys_reset_i,
  input  wire cpu_bus_t    cpu_i,
  input  wire logic        pending_flag_i,
  input  wire logic        chain_enable_in_i,
  input  wire logic        service_clear_i,
  output periph_bus_t      periph_o,
  output logic             cpu_clock_o,
  output logic             chain_enable_out_o,
  output logic             under_service_o,
  output logic             vector_enable_o
);
  localparam int unsigned TAP = `ACK_DELAY_CYC + EXTRA_WAIT;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  cpu_bus_t  s1_q, s2_q;
  logic      rst1_q, rst2_q;
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s1_q   <= '1;
      s2_q   <= '1;
      rst1_q <= 1'b0;
      rst2_q <= 1'b0;
    end else begin
      s1_q   <= cpu_i;
      s2_q   <= s1_q;
      rst1_q <= sys_reset_i;
      rst2_q <= rst1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Processor clock divider; slow clock is an enable, pin is a register
  logic [7:0] div_q, div_d;
  logic       cclk_q, cclk_d;
  logic       rise_en;
  always_comb begin
    div_d   = div_q + 8'h01;
    cclk_d  = cclk_q;
    rise_en = 1'b0;
    if (div_q == 8'(`CPU_DIV / 2 - 1)) begin
      div_d  = 8'h00;
      cclk_d = ~cclk_q;
      rise_en = ~cclk_q;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      div_q  <= 8'h00;
      cclk_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      cclk_q <= cclk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge detection and shift register
  logic                   sel_q, sel_d;
  logic                   fetch_q, fetch_d;
  logic                   ack_q, ack_d;
  logic [`SHIFT_LEN-1:0]  sh_q, sh_d;
  logic                   ack_seen;
  logic                   sel_src;

  function automatic logic io_select(input cpu_bus_t b);
    return b.periph_select & ~b.io_request_n;
  endfunction

  always_comb begin
    // Select source registered on the rising edge at fast clocks
    sel_d   = rise_en ? io_select(s2_q) : sel_q;
    sel_src = (`CPU_CLK_KHZ >= `SEL_REG_MIN_KHZ) ? sel_q
            : io_select(s2_q);
    fetch_d = fetch_q;
    ack_d   = ack_q;
    sh_d    = sh_q;
    ack_seen = ~s2_q.opcode_fetch_n & s2_q.memory_request_n;
    if (s2_q.opcode_fetch_n || rst2_q) begin
      fetch_d = 1'b0;
      ack_d   = 1'b0;
      sh_d    = '0;
    end else if (rise_en) begin
      // Fetch with memory idle at state two marks an acknowledge
      if (ack_seen) begin
        ack_d = 1'b1;
      end
      fetch_d = 1'b1;
      sh_d    = {sh_q[`SHIFT_LEN-2:0], ack_q | (ack_seen & sel_src)};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sel_q   <= 1'b0;
      fetch_q <= 1'b0;
      ack_q   <= 1'b0;
      sh_q    <= '0;
    end else begin
      sel_q   <= sel_d;
      fetch_q <= fetch_d;
      ack_q   <= ack_d;
      sh_q    <= sh_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ordinary I/O strobe shaping
  logic rd_req, wr_req, rd_str, wr_str;
  assign rd_req = ~s2_q.rd_n & s2_q.periph_select & ~fetch_q;
  assign wr_req = ~s2_q.wr_n & s2_q.periph_select & ~fetch_q;

  strobe_trim u_rd_trim (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .req_i    (rd_req),
    .strobe_o (rd_str)
  );
  strobe_trim u_wr_trim (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .req_i    (wr_req),
    .strobe_o (wr_str)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output stage and peripheral side daisy chain
  periph_bus_t po_q, po_d;
  logic        ius_q, ius_d;
  logic        ieo_q, ieo_d;
  logic        ven_q, ven_d;
  logic        ack_rd;

  always_comb begin
    // Read tap sits TAP+1 processor clock rises after ack; later tap adds settling
    ack_rd = ack_q & sh_q[TAP % `SHIFT_LEN];
    po_d.interrupt_ack_n = ~ack_q;
    if (rst2_q) begin
      po_d.periph_read_n  = 1'b0;
      po_d.periph_write_n = 1'b0;
      po_d.wait_n         = 1'b1;
      po_d.interrupt_ack_n = 1'b1;
    end else begin
      // Idle shifter: read and wait combine other logic
      po_d.periph_read_n  = ~(rd_str | ack_rd);
      po_d.periph_write_n = ~wr_str;
      po_d.wait_n = s2_q.wait_other_n & ~(ack_q & ~ack_rd);
    end
    ven_d = ~po_d.interrupt_ack_n & ~po_d.periph_read_n
          & pending_flag_i & chain_enable_in_i;
    ius_d = ius_q;
    if (service_clear_i) begin
      ius_d = 1'b0;
    end
    if (ven_d) begin
      ius_d = 1'b1;
    end
    if (ack_q) begin
      ieo_d = chain_enable_in_i & ~pending_flag_i & ~ius_q;
    end else begin
      ieo_d = chain_enable_in_i & ~ius_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      po_q  <= '1;
      ius_q <= 1'b0;
      ieo_q <= 1'b0;
      ven_q <= 1'b0;
    end else begin
      po_q  <= po_d;
      ius_q <= ius_d;
      ieo_q <= ieo_d;
      ven_q <= ven_d;
    end
  end

  assign periph_o           = po_q;
  assign cpu_clock_o        = cclk_q;
  assign chain_enable_out_o = ieo_q;
  assign under_service_o    = ius_q;
  assign vector_enable_o    = ven_q;
endmodule
`default_nettype wire

// ---- hdl/strobe_trim.sv ----
// Strobe shaper: delayed fall, early rise
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_ack_n_glue_cfg.svh"
module strobe_trim
  import interrupt_ack_n_glue_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic req_i,
  output logic      strobe_o
);
  strobe_state_t st_q, st_d;
  logic [7:0]    cnt_q, cnt_d;
  logic          strobe_q, strobe_d;

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    strobe_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        cnt_d = 8'h00;
        if (req_i) begin
          st_d = ST_LEAD;
        end
      end
      ST_LEAD: begin
        // Hold off the fall to give the address its lead
        cnt_d = cnt_q + 8'h01;
        if (!req_i) begin
          st_d = ST_IDLE;
        end else if (cnt_q >= 8'(`ADDR_LEAD_CYC - 1)) begin
          st_d     = ST_PULSE;
          strobe_d = 1'b1;
        end
      end
      ST_PULSE: begin
        // Ends as soon as the request drops, before address changes
        strobe_d = req_i;
        if (!req_i) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_q     <= ST_IDLE;
      cnt_q    <= 8'h00;
      strobe_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      strobe_q <= strobe_d;
    end
  end

  assign strobe_o = strobe_q;
endmodule
`default_nettype wire

// ---- include/interrupt_ack_n_glue_cfg.svh ----
// Constants for the interrupt acknowledge bus glue
`ifndef INTERRUPT_ACK_N_GLUE_CFG_SVH
`define INTERRUPT_ACK_N_GLUE_CFG_SVH
`define CLK_PERIOD_NS    5
`define ADDR_LEAD_NS     50
`define ADDR_LEAD_CYC    ((`ADDR_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACK_DELAY_NS     125
`define ACK_DELAY_CYC    ((`ACK_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEL_REG_MIN_KHZ  8000
`define CPU_CLK_KHZ      10000
`define CPU_DIV          20
`define SHIFT_LEN        32
`define RESET_CMD        8'hc0
`endif

// ---- include/interrupt_ack_n_glue_pkg.sv ----
// Types for the interrupt acknowledge bus glue
`default_nettype none
package interrupt_ack_n_glue_pkg;
  typedef struct packed {
    logic opcode_fetch_n;
    logic memory_request_n;
    logic io_request_n;
    logic rd_n;
    logic wr_n;
    logic periph_select;
    logic wait_other_n;
  } cpu_bus_t;
  typedef struct packed {
    logic interrupt_ack_n;
    logic periph_read_n;
    logic periph_write_n;
    logic wait_n;
  } periph_bus_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_PULSE = 2'b10
  } strobe_state_t;
endpackage
`default_nettype wire
